// ### rtl/dbm_pkg.sv
// package: register map, field positions, carrier types and helper functions of the dma mux block
package dbm_pkg;

   localparam int NCH    = 4;
   localparam int PTR_W  = 18;
   localparam int DATA_W = 16;
   localparam int RGA_W  = 8;

   // register address bus codes (processor address bits 8..1)
   localparam logic [RGA_W-1:0] RA_PTR_HI   = 8'h20;
   localparam logic [RGA_W-1:0] RA_PTR_LO   = 8'h21;
   localparam logic [RGA_W-1:0] RA_CON0     = 8'h28;
   localparam logic [RGA_W-1:0] RA_CON1     = 8'h29;
   localparam logic [RGA_W-1:0] RA_FWM      = 8'h2a;
   localparam logic [RGA_W-1:0] RA_LWM      = 8'h2b;
   localparam logic [RGA_W-1:0] RA_SIZE     = 8'h2c;
   localparam logic [RGA_W-1:0] RA_MOD      = 8'h30;
   localparam logic [RGA_W-1:0] RA_DAT      = 8'h38;
   localparam logic [RGA_W-1:0] RA_DDAT     = 8'h3b;
   localparam logic [RGA_W-1:0] RA_AUD_HI   = 8'h50;
   localparam logic [RGA_W-1:0] RA_AUD_LO   = 8'h51;
   localparam logic [RGA_W-1:0] RA_PAIR     = 8'h02;
   localparam logic [RGA_W-1:0] RA_SINGLE   = 8'h01;
   localparam logic [RGA_W-1:0] RA_IDLE     = 8'hff;

   // pointer split: high word holds bits 17..15, low word bits 14..0 in data bits 15..1
   localparam int PTR_SPLIT = 15;
   localparam int PTR_HI_W  = 3;

   // first control register fields
   localparam int CON0_ASH_HI = 15;
   localparam int CON0_ASH_LO = 12;
   localparam int CON0_USE_A  = 11;
   localparam int CON0_USE_D  = 8;
   localparam int CON0_LF_HI  = 7;
   localparam int CON0_LF_LO  = 0;
   // second control register fields
   localparam int CON1_BSH_HI = 15;
   localparam int CON1_BSH_LO = 12;
   localparam int CON1_EFE    = 4;
   localparam int CON1_IFE    = 3;
   localparam int CON1_FCI    = 2;
   localparam int CON1_DESCENDING_ADDR   = 1;
   localparam int CON1_LINE   = 0;
   // size register fields
   localparam int SIZE_H_HI = 15;
   localparam int SIZE_H_LO = 6;
   localparam int SIZE_W_HI = 5;
   localparam int SIZE_W_LO = 0;

   localparam logic [DATA_W-1:0] ALL_ONES = 16'hffff;
   localparam logic [6:0]        W_FULL   = 7'h40;
   localparam logic [10:0]       H_FULL   = 11'h400;

   localparam logic [1:0] CH_A = 2'h0;
   localparam logic [1:0] CH_B = 2'h1;
   localparam logic [1:0] CH_C = 2'h2;
   localparam logic [1:0] CH_D = 2'h3;
   localparam logic [1:0] FIFO_DEPTH = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_FETCH_A = 3'b001,
      ST_FETCH_B = 3'b010,
      ST_FETCH_C = 3'b011,
      ST_COMPUTE = 3'b100
   } dbm_fsm_t;

   typedef struct packed {
      logic              cpu_addr_strobe_n;
      logic              register_enable_n;
      logic              cpu_rw_in;
      logic [RGA_W-1:0]  addr;
      logic [DATA_W-1:0] data;
   } dbm_cpu_t;

   typedef struct packed {
      logic              valid;
      logic              refresh;
      logic              write;
      logic [PTR_W-1:0]  addr;
      logic [RGA_W-1:0]  register_addr_bus;
   } dbm_dma_req_t;

   typedef struct packed {
      logic              bus_request_n;
      logic              row_strobe_first_n;
      logic              row_strobe_second_n;
      logic              column_strobe_upper_n;
      logic              column_strobe_lower_n;
      logic [PTR_W-1:0]  memory_addr_bus;
      logic [DATA_W-1:0] data;
      logic              data_oe;
   } dbm_ram_t;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [PTR_W-1:0]  addr;
   } dbm_word_t;

   typedef struct packed {
      dbm_ram_t                     ram;
      logic [RGA_W-1:0]             register_addr_bus;
      logic                         register_rw_out;
      logic [DATA_W-1:0]            cpu_dout;
      logic                         cpu_doe;
      logic                         cpu_done;
      logic                         busy;
      logic [NCH-1:0][PTR_W-1:0]    aud_loc;
      logic [NCH-1:0][PTR_W-1:0]    ptr;
      logic [NCH-1:0][DATA_W-1:0]   modu;
      logic [2:0][DATA_W-1:0]       dat;
      logic [DATA_W-1:0]            fwm;
      logic [DATA_W-1:0]            lwm;
      logic [DATA_W-1:0]            ddat;
      logic [DATA_W-1:0]            con0;
      logic [DATA_W-1:0]            con1;
      logic [DATA_W-1:0]            prev_a;
      logic [DATA_W-1:0]            prev_b;
      logic                         fill_c;
      logic                         cap_valid;
      logic [1:0]                   cap_sel;
      dbm_fsm_t                     fsm;
      logic [6:0]                   word_cnt;
      logic [6:0]                   width;
      logic [10:0]                  line_cnt;
      logic [10:0]                  lines;
      dbm_word_t [1:0]              fifo;
      logic [1:0]                   fifo_cnt;
      logic                         fifo_wr;
      logic                         fifo_rd;
   } dbm_st_t;

   function automatic logic [RGA_W-1:0] reg_code(input logic [RGA_W-1:0] base, input logic [RGA_W-1:0] step,
                                                 input int x);
      return base + step * RGA_W'(x);
   endfunction

   function automatic logic [PTR_W-1:0] ptr_move(input logic [PTR_W-1:0] p, input logic inc,
                                                 input logic [DATA_W-1:0] m, input logic use_mod,
                                                 input logic descending_addr);
      logic [PTR_W-1:0] d;
      d = {{(PTR_W-1){1'b0}}, inc} + (use_mod ? {{PTR_HI_W{m[DATA_W-1]}}, m[DATA_W-1:1]} : {PTR_W{1'b0}});
      return descending_addr ? p - d : p + d;
   endfunction

   function automatic logic [DATA_W-1:0] shift_word(input logic [DATA_W-1:0] cur, input logic [DATA_W-1:0] prev,
                                                    input logic [3:0] sh, input logic descending_addr);
      logic [2*DATA_W-1:0] t;
      t = descending_addr ? ({cur, prev} << sh) : ({prev, cur} >> sh);
      return descending_addr ? t[2*DATA_W-1:DATA_W] : t[DATA_W-1:0];
   endfunction

   function automatic logic [DATA_W-1:0] minterm(input logic [7:0] lf, input logic [DATA_W-1:0] a,
                                                 input logic [DATA_W-1:0] b, input logic [DATA_W-1:0] c);
      logic [DATA_W-1:0] o;
      o = '0;
      for (int i = 0; i < DATA_W; i++) begin
         o[i] = lf[{a[i], b[i], c[i]}];
      end
      return o;
   endfunction

   function automatic logic [DATA_W:0] fill_word(input logic [DATA_W-1:0] w, input logic c_in, input logic excl);
      logic              c;
      logic [DATA_W-1:0] o;
      c = c_in;
      o = '0;
      for (int i = 0; i < DATA_W; i++) begin
         c    = c ^ w[i];
         o[i] = excl ? c : (c | w[i]);
      end
      return {c, o};
   endfunction

endpackage

// ### rtl/dbm_top.sv
// dma bus multiplexer with block transfer register set and sequencer
`timescale 1ns/1ps

module dbm_top
   import dbm_pkg::*;
(
   // clock and reset
   input  wire logic         SYS_CLK_I,
   input  wire logic         RST_I,
   // processor register port
   input  wire dbm_cpu_t     CPU_I,
   output logic [DATA_W-1:0] CPU_DATA_O,
   output logic              CPU_DATA_OE_O,
   // dma slot request from other controllers
   input  wire dbm_dma_req_t DMA_REQ_I,
   // ram side
   input  wire logic [DATA_W-1:0] RAM_DATA_I,
   input  wire logic         RAM_WR_READY_I,
   output dbm_ram_t          RAM_O,
   // register address bus
   output logic [RGA_W-1:0]  REGISTER_ADDR_BUS_O,
   output logic              REGISTER_RW_OUT_O,
   // status
   output logic              BLIT_BUSY_O
);

   dbm_st_t st;
   dbm_st_t next_st;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic              ext;
      logic              drain;
      logic              fetch;
      logic              want;
      logic              cpu_req;
      logic              cpu_go;
      logic              push;
      logic              descending_addr;
      logic              last;
      logic [1:0]        ch;
      logic [DATA_W-1:0] a_m;
      logic [DATA_W-1:0] sa;
      logic [DATA_W-1:0] sb;
      logic [DATA_W-1:0] res;
      logic [DATA_W-1:0] rd;
      logic [DATA_W-1:0] wd;
      logic [RGA_W-1:0]  ra;
      logic [DATA_W:0]   fo;
      ext     = DMA_REQ_I.valid;
      drain   = 1'b0;
      fetch   = 1'b0;
      want    = 1'b0;
      cpu_req = !CPU_I.cpu_addr_strobe_n && !CPU_I.register_enable_n;
      cpu_go  = 1'b0;
      push    = 1'b0;
      descending_addr    = st.con1[CON1_DESCENDING_ADDR];
      last    = 1'b0;
      ch      = st.fsm[1:0] - 2'h1;
      a_m     = '0;
      sa      = '0;
      sb      = '0;
      res     = '0;
      rd      = '0;
      wd      = CPU_I.data;
      ra      = CPU_I.addr;
      fo      = '0;
      next_st = st;

      // idle bus outputs
      next_st.ram.bus_request_n         = 1'b1;
      next_st.ram.row_strobe_first_n    = 1'b1;
      next_st.ram.row_strobe_second_n   = 1'b1;
      next_st.ram.column_strobe_upper_n = 1'b1;
      next_st.ram.column_strobe_lower_n = 1'b1;
      next_st.ram.memory_addr_bus       = '0;
      next_st.ram.data                  = '0;
      next_st.ram.data_oe               = 1'b0;
      next_st.register_addr_bus                       = RA_IDLE;
      next_st.register_rw_out                       = 1'b1;

      // slot arbitration: other controllers, then result write, then source fetch, then processor
      drain = !ext && (st.fifo_cnt != 2'h0) && RAM_WR_READY_I;
      if ((st.fsm == ST_FETCH_A) || (st.fsm == ST_FETCH_B) || (st.fsm == ST_FETCH_C)) begin
         want = st.con0[CON0_USE_A - int'(ch)];
      end
      fetch  = want && !ext && !drain;
      cpu_go = cpu_req && !st.cpu_done && !ext && !drain && !fetch;

      if (ext) begin
         next_st.ram.bus_request_n         = 1'b0;
         next_st.ram.memory_addr_bus       = DMA_REQ_I.addr;
         next_st.ram.row_strobe_first_n    = 1'b0;
         next_st.ram.row_strobe_second_n   = !DMA_REQ_I.refresh;
         next_st.ram.column_strobe_upper_n = DMA_REQ_I.refresh;
         next_st.ram.column_strobe_lower_n = DMA_REQ_I.refresh;
         next_st.register_addr_bus                       = DMA_REQ_I.register_addr_bus;
         next_st.register_rw_out                       = !DMA_REQ_I.write;
      end else if (drain || fetch) begin
         next_st.ram.bus_request_n         = 1'b0;
         next_st.ram.row_strobe_first_n    = 1'b0;
         next_st.ram.column_strobe_upper_n = 1'b0;
         next_st.ram.column_strobe_lower_n = 1'b0;
         if (drain) begin
            next_st.ram.memory_addr_bus = st.fifo[st.fifo_rd].addr;
            next_st.ram.data            = st.fifo[st.fifo_rd].data;
            next_st.ram.data_oe         = 1'b1;
            next_st.register_addr_bus                 = RA_DDAT;
            next_st.register_rw_out                 = 1'b0;
         end else begin
            next_st.ram.memory_addr_bus = st.ptr[ch];
            next_st.register_addr_bus                 = reg_code(RA_DAT, RA_SINGLE, int'(ch));
            next_st.ptr[ch]             = ptr_move(st.ptr[ch], 1'b1, '0, 1'b0, descending_addr);
         end
      end else if (cpu_go) begin
         next_st.register_addr_bus = CPU_I.addr;
         next_st.register_rw_out = CPU_I.cpu_rw_in;
      end

      // fetched word arrives one cycle after its slot
      if (st.cap_valid) begin
         next_st.dat[st.cap_sel] = RAM_DATA_I;
      end
      next_st.cap_valid = fetch;
      next_st.cap_sel   = ch;

      // result buffer drain
      if (drain) begin
         next_st.fifo_rd = !st.fifo_rd;
      end

      // transfer sequencer
      case (st.fsm)
         ST_IDLE: begin
         end
         ST_FETCH_A, ST_FETCH_B, ST_FETCH_C: begin
            if (!want || fetch) begin
               next_st.fsm = (st.fsm == ST_FETCH_C) ? ST_COMPUTE : dbm_fsm_t'(st.fsm + 3'b001);
            end
         end
         ST_COMPUTE: begin
            if (!st.cap_valid && (st.fifo_cnt != FIFO_DEPTH)) begin
               last = (st.word_cnt == st.width - 7'h01);
               a_m  = st.dat[CH_A];
               if (st.word_cnt == 7'h00) begin
                  a_m = a_m & st.fwm;
               end
               if (last) begin
                  a_m = a_m & st.lwm;
               end
               sa  = shift_word(a_m, st.prev_a, st.con0[CON0_ASH_HI:CON0_ASH_LO], descending_addr);
               sb  = shift_word(st.dat[CH_B], st.prev_b, st.con1[CON1_BSH_HI:CON1_BSH_LO], descending_addr);
               res = minterm(st.con0[CON0_LF_HI:CON0_LF_LO], sa, sb, st.dat[CH_C]);
               fo  = fill_word(res, st.fill_c, st.con1[CON1_EFE]);
               if (st.con1[CON1_EFE] || st.con1[CON1_IFE]) begin
                  res = fo[DATA_W-1:0];
               end
               next_st.fill_c = fo[DATA_W];
               next_st.prev_a = a_m;
               next_st.prev_b = st.dat[CH_B];
               next_st.ddat   = res;
               if (st.con0[CON0_USE_D]) begin
                  push                    = 1'b1;
                  next_st.fifo[st.fifo_wr] = '{data: res, addr: st.ptr[CH_D]};
                  next_st.fifo_wr          = !st.fifo_wr;
                  next_st.ptr[CH_D] = ptr_move(st.ptr[CH_D], 1'b1, st.modu[CH_D], last, descending_addr);
               end
               if (last) begin
                  for (int x = 0; x < NCH - 1; x++) begin
                     if (st.con0[CON0_USE_A - x]) begin
                        next_st.ptr[x] = ptr_move(st.ptr[x], 1'b0, st.modu[x], 1'b1, descending_addr);
                     end
                  end
                  next_st.word_cnt = '0;
                  next_st.fill_c   = st.con1[CON1_FCI];
                  next_st.line_cnt = st.line_cnt + 11'h001;
                  next_st.fsm      = (st.line_cnt == st.lines - 11'h001) ? ST_IDLE : ST_FETCH_A;
               end else begin
                  next_st.word_cnt = st.word_cnt + 7'h01;
                  next_st.fsm      = ST_FETCH_A;
               end
            end
         end
         default: begin
            next_st.fsm = ST_IDLE;
         end
      endcase

      if (push && !drain) begin
         next_st.fifo_cnt = st.fifo_cnt + 2'h1;
      end else if (drain && !push) begin
         next_st.fifo_cnt = st.fifo_cnt - 2'h1;
      end

      // processor register read and write
      for (int x = 0; x < NCH; x++) begin
         if (ra == reg_code(RA_AUD_HI, RA_PAIR, x)) begin
            rd = {{(DATA_W-PTR_HI_W){1'b0}}, st.aud_loc[x][PTR_W-1:PTR_SPLIT]};
         end
         if (ra == reg_code(RA_AUD_LO, RA_PAIR, x)) begin
            rd = {st.aud_loc[x][PTR_SPLIT-1:0], 1'b0};
         end
         if (ra == reg_code(RA_PTR_HI, RA_PAIR, x)) begin
            rd = {{(DATA_W-PTR_HI_W){1'b0}}, st.ptr[x][PTR_W-1:PTR_SPLIT]};
         end
         if (ra == reg_code(RA_PTR_LO, RA_PAIR, x)) begin
            rd = {st.ptr[x][PTR_SPLIT-1:0], 1'b0};
         end
         if (ra == reg_code(RA_MOD, RA_SINGLE, x)) begin
            rd = st.modu[x];
         end
         if ((x < NCH - 1) && (ra == reg_code(RA_DAT, RA_SINGLE, x))) begin
            rd = st.dat[x];
         end
      end
      case (ra)
         RA_CON0: rd = st.con0;
         RA_CON1: rd = st.con1;
         RA_FWM:  rd = st.fwm;
         RA_LWM:  rd = st.lwm;
         default: begin
         end
      endcase

      if (cpu_go && !CPU_I.cpu_rw_in) begin
         for (int x = 0; x < NCH; x++) begin
            if (ra == reg_code(RA_AUD_HI, RA_PAIR, x)) begin
               next_st.aud_loc[x][PTR_W-1:PTR_SPLIT] = wd[PTR_HI_W-1:0];
            end
            if (ra == reg_code(RA_AUD_LO, RA_PAIR, x)) begin
               next_st.aud_loc[x][PTR_SPLIT-1:0] = wd[DATA_W-1:1];
            end
            if (ra == reg_code(RA_PTR_HI, RA_PAIR, x)) begin
               next_st.ptr[x][PTR_W-1:PTR_SPLIT] = wd[PTR_HI_W-1:0];
            end
            if (ra == reg_code(RA_PTR_LO, RA_PAIR, x)) begin
               next_st.ptr[x][PTR_SPLIT-1:0] = wd[DATA_W-1:1];
            end
            if (ra == reg_code(RA_MOD, RA_SINGLE, x)) begin
               next_st.modu[x] = wd;
            end
            if ((x < NCH - 1) && (ra == reg_code(RA_DAT, RA_SINGLE, x))) begin
               next_st.dat[x] = wd;
            end
         end
         case (ra)
            RA_CON0: next_st.con0 = wd;
            RA_CON1: next_st.con1 = wd;
            RA_FWM:  next_st.fwm  = wd;
            RA_LWM:  next_st.lwm  = wd;
            RA_DDAT: next_st.ddat = wd;
            RA_SIZE: begin
               if (!st.busy && !st.con1[CON1_LINE]) begin
                  next_st.width    = (wd[SIZE_W_HI:SIZE_W_LO] == '0) ? W_FULL : {1'b0, wd[SIZE_W_HI:SIZE_W_LO]};
                  next_st.lines    = (wd[SIZE_H_HI:SIZE_H_LO] == '0) ? H_FULL : {1'b0, wd[SIZE_H_HI:SIZE_H_LO]};
                  next_st.word_cnt = '0;
                  next_st.line_cnt = '0;
                  next_st.prev_a   = '0;
                  next_st.prev_b   = '0;
                  next_st.fill_c   = st.con1[CON1_FCI];
                  next_st.fsm      = ST_FETCH_A;
               end
            end
            default: begin
            end
         endcase
      end

      // read data stands while the strobes stay low
      if (cpu_go && CPU_I.cpu_rw_in) begin
         next_st.cpu_dout = rd;
      end
      next_st.cpu_doe  = cpu_req && CPU_I.cpu_rw_in && (st.cpu_done || cpu_go);
      next_st.cpu_done = cpu_req && (st.cpu_done || cpu_go);
      if (!cpu_req) begin
         next_st.cpu_dout = '0;
      end
      next_st.busy = (next_st.fsm != ST_IDLE) || (next_st.fifo_cnt != 2'h0);
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         st                           <= '0;
         st.ram.bus_request_n         <= 1'b1;
         st.ram.row_strobe_first_n    <= 1'b1;
         st.ram.row_strobe_second_n   <= 1'b1;
         st.ram.column_strobe_upper_n <= 1'b1;
         st.ram.column_strobe_lower_n <= 1'b1;
         st.register_addr_bus                       <= RA_IDLE;
         st.register_rw_out                       <= 1'b1;
         st.fwm                       <= ALL_ONES;
         st.lwm                       <= ALL_ONES;
         st.width                     <= W_FULL;
         st.lines                     <= H_FULL;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign RAM_O               = st.ram;
   assign REGISTER_ADDR_BUS_O = st.register_addr_bus;
   assign REGISTER_RW_OUT_O   = st.register_rw_out;
   assign CPU_DATA_O          = st.cpu_dout;
   assign CPU_DATA_OE_O       = st.cpu_doe;
   assign BLIT_BUSY_O         = st.busy;

endmodule

// ### tb/dbm_properties.sv
// checker: port properties of the dma mux block
`timescale 1ns/1ps
module dbm_properties
   import dbm_pkg::*;
(
   // clock and reset
   input wire logic         SYS_CLK_I,
   input wire logic         RST_I,
   // watched ports
   input wire dbm_cpu_t     CPU_I,
   input wire dbm_dma_req_t DMA_REQ_I,
   input wire dbm_ram_t     RAM_O,
   input wire logic [7:0]   REGISTER_ADDR_BUS_O,
   input wire logic         REGISTER_RW_OUT_O,
   input wire logic         CPU_DATA_OE_O,
   input wire logic         BLIT_BUSY_O
);
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);
   a_dma_request: assert property (DMA_REQ_I.valid |=> !RAM_O.bus_request_n &&
      RAM_O.memory_addr_bus == $past(DMA_REQ_I.addr)) else $error("dma address missing");
   a_dma_rows: assert property (DMA_REQ_I.valid |=> !RAM_O.row_strobe_first_n &&
      RAM_O.row_strobe_second_n == !$past(DMA_REQ_I.refresh)) else $error("row strobes wrong");
   a_dma_columns: assert property (DMA_REQ_I.valid |=> RAM_O.column_strobe_upper_n ==
      $past(DMA_REQ_I.refresh) && RAM_O.column_strobe_lower_n == $past(DMA_REQ_I.refresh))
      else $error("column strobes wrong");
   a_refresh_quiet: assert property (!RAM_O.row_strobe_second_n |->
      RAM_O.column_strobe_upper_n && RAM_O.column_strobe_lower_n) else $error("column strobe in refresh");
   a_dma_code: assert property (DMA_REQ_I.valid |=> REGISTER_ADDR_BUS_O == $past(DMA_REQ_I.register_addr_bus))
      else $error("dma register code missing");
   a_dma_dir: assert property (DMA_REQ_I.valid |=> REGISTER_RW_OUT_O == !$past(DMA_REQ_I.write))
      else $error("dma direction wrong");
   a_cpu_read: assert property ($rose(CPU_DATA_OE_O) |-> REGISTER_RW_OUT_O &&
      REGISTER_ADDR_BUS_O == $past(CPU_I.addr)) else $error("cpu read not reflected");
   a_read_held: assert property (CPU_DATA_OE_O |-> !$past(CPU_I.cpu_addr_strobe_n) &&
      !$past(CPU_I.register_enable_n)) else $error("read data without strobes");
   cover property (DMA_REQ_I.valid && DMA_REQ_I.refresh);
   cover property ($rose(CPU_DATA_OE_O));
   cover property ($fell(BLIT_BUSY_O));
endmodule
bind dbm_top dbm_properties i_props (.SYS_CLK_I, .RST_I, .CPU_I, .DMA_REQ_I, .RAM_O,
   .REGISTER_ADDR_BUS_O, .REGISTER_RW_OUT_O, .CPU_DATA_OE_O, .BLIT_BUSY_O);

// ### tb/dbm_ram_model.sv
// ram array model: answers fetch slots, takes result writes, stalls at random
`timescale 1ns/1ps
module dbm_ram_model
   import dbm_pkg::*;
(
   input  wire logic         clk_i,
   input  wire dbm_ram_t     ram_i,
   output logic [DATA_W-1:0] rdata_o,
   output logic              ready_o
);
   logic [DATA_W-1:0] mem [256];
   logic [DATA_W-1:0] last_rd;
   logic              rd_slot;
   assign rd_slot = !ram_i.row_strobe_first_n && !ram_i.data_oe;
   // read word stands during its own slot; between slots the bus shows the inverse of the last word
   assign rdata_o = rd_slot ? mem[ram_i.memory_addr_bus[7:0]] : ~last_rd;
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = {8'h5a, 8'(i)};
      last_rd = 16'h0000;
      ready_o = 1'b0;
   end
   always @(posedge clk_i) begin
      ready_o <= ($urandom % 3) != 0;
      if (rd_slot) last_rd <= mem[ram_i.memory_addr_bus[7:0]];
      if (!ram_i.row_strobe_first_n && ram_i.data_oe) mem[ram_i.memory_addr_bus[7:0]] <= ram_i.data;
   end
endmodule

// ### tb/testbench.sv
// self-checking bench for the dma mux block
`timescale 1ns/1ps
module testbench
   import dbm_pkg::*;
;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   dbm_cpu_t          cpu = '1;
   dbm_dma_req_t      dma = '0;
   dbm_ram_t          ram;
   logic [DATA_W-1:0] rdata, dout;
   logic [7:0]        register_addr_bus;
   logic              rdy, oe, busy, register_rw_out;
   logic              oe_d = 1'b0;
   int                failures = 0;
   int                comparisons = 0;
   logic [33:0]       rq[$], wq[$];
   initial forever #25 clk = ~clk;
   dbm_top i_dut (.SYS_CLK_I(clk), .RST_I(rst), .CPU_I(cpu), .CPU_DATA_O(dout), .CPU_DATA_OE_O(oe),
      .DMA_REQ_I(dma), .RAM_DATA_I(rdata), .RAM_WR_READY_I(rdy), .RAM_O(ram),
      .REGISTER_ADDR_BUS_O(register_addr_bus), .REGISTER_RW_OUT_O(register_rw_out), .BLIT_BUSY_O(busy));
   dbm_ram_model i_ram (.clk_i(clk), .ram_i(ram), .rdata_o(rdata), .ready_o(rdy));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(string name, logic [33:0] exp, logic [33:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic acc(logic rw, logic [7:0] a, logic [15:0] d);
      int n;
      n = 0;
      cpu <= '{1'b0, 1'b0, rw, a, d};
      do @(negedge clk); while (!(register_addr_bus === a && register_rw_out === rw) && ++n < 50);
      if (n >= 50) failures++;
      @(posedge clk) cpu <= '1;
      @(posedge clk);
   endtask
   task automatic wr(logic [7:0] a, logic [15:0] d);
      acc(1'b0, a, d);
   endtask
   task automatic rd(logic [7:0] a, logic [15:0] e);
      rq.push_back(34'(e));
      acc(1'b1, a, 16'h0000);
   endtask
   task automatic wptr(logic [7:0] a, logic [17:0] p);
      wr(a, {13'h0, p[17:15]});
      wr(a + 8'h01, {p[14:0], 1'b0});
   endtask
   task automatic blit(logic [15:0] size);
      int n;
      n = 0;
      wr(RA_SIZE, size);
      do @(negedge clk); while (busy !== 1'b0 && ++n < 500);
      check("blit done", 1'b0, busy);
      @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(negedge clk) begin
      oe_d <= oe;
      if (oe === 1'b1 && oe_d === 1'b0) check("read data", rq.pop_front(), 34'(dout));
      if (ram.data_oe === 1'b1 && register_addr_bus === RA_DDAT)
         check("ram write", wq.pop_front(), {ram.memory_addr_bus, ram.data});
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      end_of_test();
   end
   initial begin
      logic [17:0] p;
      logic [15:0] v, fm, lm;
      void'($urandom(62));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(RA_FWM, ALL_ONES);
      rd(RA_DDAT, 16'h0000);
      rd(8'h7e, 16'h0000);
      for (int x = 0; x < 4; x++) begin
         p = 18'($urandom);
         v = 16'($urandom);
         wptr(RA_AUD_HI + 8'(2 * x), p);
         rd(RA_AUD_HI + 8'(2 * x), {13'h0, p[17:15]});
         rd(RA_AUD_LO + 8'(2 * x), {p[14:0], 1'b0});
         wr(RA_DAT + 8'(x % 3), v);
         rd(RA_DAT + 8'(x % 3), v);
         wr(RA_CON0 + 8'(x % 2), v);
         rd(RA_CON0 + 8'(x % 2), v);
      end
      for (int k = 0; k < 8; k++) begin
         dma <= '{1'b1, k[0], k[1], 18'($urandom), 8'($urandom)};
         @(posedge clk);
      end
      dma <= '0;
      wr(RA_DAT, 16'h8000);
      wr(RA_DAT + 8'h01, 16'h00ff);
      wr(RA_CON1, 16'h0001);
      wr(RA_SIZE, 16'h0042);
      @(negedge clk);
      check("line busy", 1'b0, busy);
      @(posedge clk);
      fm = 16'($urandom);
      lm = 16'($urandom);
      wr(RA_FWM, fm);
      wr(RA_LWM, lm);
      wr(RA_CON1, 16'h0000);
      wr(RA_CON0, 16'h09f0);
      wptr(RA_PTR_HI, 18'h10);
      wptr(RA_PTR_HI + 8'h06, 18'h40);
      wr(RA_MOD, 16'h0004);
      wr(RA_MOD + 8'h03, 16'h0000);
      wq.push_back({18'h40, 16'h5a10 & fm});
      wq.push_back({18'h41, 16'h5a11 & lm});
      blit(16'h0042);
      rd(RA_PTR_LO, {15'h14, 1'b0});
      rd(RA_PTR_LO + 8'h06, {15'h42, 1'b0});
      wr(RA_FWM, ALL_ONES);
      wr(RA_LWM, ALL_ONES);
      wr(RA_CON1, 16'h0012);
      wq.push_back({18'h42, 16'h360c});
      blit(16'h0041);
      rd(RA_PTR_LO, {15'h11, 1'b0});
      rd(RA_PTR_LO + 8'h06, {15'h41, 1'b0});
      check("writes left", 34'h0, 34'(wq.size()));
      end_of_test();
   end
endmodule
